// ==== ldr_pkg.sv ====
package ldr_pkg;
   // ----------------------------------------------------------------
   // Configuration indices
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_LD_NUM = 8'h07;
   localparam logic [7:0] IDX_OSC_CFG = 8'h24;
   localparam logic [7:0] IDX_CFG_BASE_LO = 8'h26;
   localparam logic [7:0] IDX_CFG_BASE_HI = 8'h27;
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
   localparam logic [7:0] IDX_DMA_SEL = 8'h74;
   localparam logic [7:0] IDX_LD_FIRST = 8'h30;

   // ----------------------------------------------------------------
   // Logical device numbers and bank slots
   // ----------------------------------------------------------------
   localparam logic [7:0] LD_FLOPPY = 8'h00;
   localparam logic [7:0] LD_PARALLEL = 8'h03;
   localparam logic [7:0] LD_SERIAL1 = 8'h04;
   localparam logic [7:0] LD_SERIAL2 = 8'h05;
   localparam int SLOT_FLOPPY = 0;
   localparam int SLOT_PARALLEL = 1;
   localparam int SLOT_SERIAL1 = 2;
   localparam int SLOT_SERIAL2 = 3;
   localparam int NUM_LD = 4;
   localparam int NUM_IRQ = 16;
   localparam int NUM_DMA = 3;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] IRQ_SEL_RST_FLOPPY = 8'h06;
   localparam logic [7:0] IRQ_SEL_RST_OTHER = 8'h00;
   localparam logic [7:0] DMA_SEL_RST_FLOPPY = 8'h02;
   localparam logic [7:0] DMA_SEL_RST_OTHER = 8'h04;
   localparam logic [15:0] CFG_BASE_STRAP0 = 16'h002E;
   localparam logic [15:0] CFG_BASE_STRAP1 = 16'h004E;
   localparam int OSC_FULL_DECODE_BIT = 6;
   localparam logic [11:0] DEV_SPAN_MASK = 12'hFF8;
   localparam logic [11:0] EXACT_MASK = 12'hFFF;
   localparam logic [2:0] ECP_MODE_FIFO = 3'h2;
   localparam logic [2:0] ECP_MODE_ECP = 3'h3;
   localparam logic [2:0] ECP_MODE_TEST = 3'h6;

   // Nonzero select picks a line
   function automatic logic irq_sel_valid(input logic [3:0] sel);
      irq_sel_valid = (sel != 4'h0);
   endfunction

   // Only one to three name a channel
   function automatic logic dma_sel_valid(input logic [2:0] sel);
      dma_sel_valid = (sel >= 3'h1) && (sel <= 3'h3);
   endfunction
endpackage

// ==== ld_cfg_bank.sv ====
`timescale 1ns/1ps
module ld_cfg_bank import ldr_pkg::*; #(
   parameter logic [7:0] IRQ_RST = 8'h00,
   parameter logic [7:0] DMA_RST = 8'h04
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [7:0] index,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic activate,
   output logic [15:0] base,
   output logic [3:0] irq_sel,
   output logic [2:0] dma_sel
);
   logic activate_reg;
   logic [15:0] base_reg;
   logic [3:0] irq_sel_reg;
   logic [2:0] dma_sel_reg;

   // ----------------------------------------------------------------
   // Activate and base, hard reset only
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         activate_reg <= 1'b0;
         base_reg <= 16'h0000;
      end else if (ce && wr_en) begin
         if (index == IDX_ACTIVATE) activate_reg <= wdata[0];
         if (index == IDX_BASE_HI) base_reg[15:8] <= wdata;
         if (index == IDX_BASE_LO) base_reg[7:0] <= wdata;
      end
   end

   // Selects also return to default on soft reset
   always_ff @(posedge ref_clk) begin
      if (rst || (ce && soft_rst)) begin
         irq_sel_reg <= IRQ_RST[3:0]; // R6
         dma_sel_reg <= DMA_RST[2:0]; // R14
      end else if (ce && wr_en) begin
         if (index == IDX_IRQ_SEL) irq_sel_reg <= wdata[3:0]; // R3
         if (index == IDX_DMA_SEL) dma_sel_reg <= wdata[2:0]; // R13
      end
   end

   // Read back, unused bits as zero
   always_comb begin
      case (index)
         IDX_ACTIVATE: rdata = {7'h00, activate_reg};
         IDX_BASE_HI: rdata = base_reg[15:8];
         IDX_BASE_LO: rdata = base_reg[7:0];
         IDX_IRQ_SEL: rdata = {4'h0, irq_sel_reg};
         IDX_DMA_SEL: rdata = {5'h00, dma_sel_reg};
         default: rdata = 8'h00;
      endcase
   end

   assign activate = activate_reg;
   assign base = base_reg;
   assign irq_sel = irq_sel_reg;
   assign dma_sel = dma_sel_reg;
endmodule

// ==== irq_dma_router.sv ====
`timescale 1ns/1ps
module irq_dma_router import ldr_pkg::*; #(
   parameter int NLD = 4,
   parameter int NIRQ = 16,
   parameter int NDMA = 3
) (
   input wire logic [NLD-1:0][3:0] irq_sel,
   input wire logic [NLD-1:0][2:0] dma_sel,
   input wire logic [NLD-1:0] ld_live,
   input wire logic [NLD-1:0] irq_gate,
   input wire logic [NLD-1:0] dma_gate,
   input wire logic [NLD-1:0] irq_req,
   input wire logic [NLD-1:0] dma_req,
   input wire logic [NDMA-1:0] dack,
   input wire logic [NIRQ-1:0] irq_avail,
   output logic [NIRQ-1:0] irq_level,
   output logic [NIRQ-1:0] irq_used,
   output logic [NDMA-1:0] dma_level,
   output logic [NDMA-1:0] dma_used,
   output logic [NLD-1:0] dack_out
);
   // ----------------------------------------------------------------
   // Fan-in of every logical device onto lines and channels
   // ----------------------------------------------------------------
   // Two devices on one line are ORed; software must avoid that clash
   always_comb begin
      logic [1:0] ch;
      ch = 2'h0;
      irq_level = '0;
      irq_used = '0;
      dma_level = '0;
      dma_used = '0;
      dack_out = '0;
      for (int i = 0; i < NLD; i++) begin
         // Line driven only when a live, enabled device chose it
         if (irq_sel_valid(irq_sel[i]) && ld_live[i] && irq_gate[i] &&
             irq_avail[irq_sel[i]]) begin // R10
            irq_used[irq_sel[i]] = 1'b1; // R12
            irq_level[irq_sel[i]] = irq_level[irq_sel[i]] | irq_req[i]; // R7
         end
         // A gated-off function releases its channel as if unselected
         if (dma_sel_valid(dma_sel[i]) && ld_live[i] && dma_gate[i]) begin // R16
            ch = 2'(dma_sel[i] - 3'h1);
            dma_used[ch] = 1'b1;
            // Gate off means the request is ignored outright
            dma_level[ch] = dma_level[ch] | (dma_gate[i] & dma_req[i]); // R15
            dack_out[i] = dma_gate[i] & dack[ch]; // R17
         end
      end
   end
endmodule

// ==== ld_irq_dma_top.sv ====
`timescale 1ns/1ps
// Contract
// [R1] Base decode uses A11..A0; full 16-bit needs osc bit 6 and upper zero.
// [R2] Config port starts at 0x02E or 0x04E per strap; relocatable by 0x26/0x27.
// [R3] Index 0x70 low nibble picks interrupt line; zero none, two shared with SMI.
// [R4] Interrupt outputs are active-high, ECP/EPP parallel port excepted; code drives every line active-high, parallel_epp_mode unused.
// [R5] System-management interrupt output is driven low when asserted.
// [R6] Interrupt select resets to 0x00, floppy to 0x06, on every reset.
// [R7] Interrupt active only with nonzero select and function enable; floppy uses DMA gate.
// [R8] Parallel interrupt needs port gate; in ECP also service mask cleared.
// [R9] Serial interrupt needs some of enable bits 0-3 and aux output two.
// [R10] Unselected interrupt lines stay disabled and undriven.
// [R11] Software disables the SMI function before giving line 2 to a device.
// [R12] In serialized interrupt mode every line may be assigned.
// [R13] Index 0x74 low three bits: zero reserved, 1-3 channels, 4-7 none.
// [R14] DMA select resets 0x02 floppy, 0x04 devices three and five.
// [R15] DMA active only for select 1-3 with the function's DMA gate set.
// [R16] Unselected DMA channels stay disabled, request and acknowledge undriven.
// [R17] Function-internal disable also kills routed interrupt and DMA.
// [R18] Floppy gate low or power-down disables its interrupt and DMA.
// [R19] ECP DMA follows ECP gate; interrupt forced on in modes 010, 011, 110.
// [R20] Index written at config port, register data at port plus one.
module ld_irq_dma_top import ldr_pkg::*; #(
   parameter logic [NUM_IRQ-1:0] DIRECT_IRQ_AVAIL = 16'hFFFF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire logic ce,
   input wire logic cfg_port_select_strap,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   output logic [NUM_LD-1:0] dev_hit,
   input wire logic serial_irq_mode,
   input wire logic floppy_dma_gate,
   input wire logic floppy_powered_down,
   input wire logic port_irq_gate,
   input wire logic parallel_ecp_mode,
   input wire logic parallel_epp_mode,
   input wire logic [2:0] ecp_mode_field,
   input wire logic ecp_service_irq_mask,
   input wire logic ecp_dma_gate,
   input wire logic [3:0] uart1_irq_enable_reg,
   input wire logic uart1_aux_output_two,
   input wire logic [3:0] uart2_irq_enable_reg,
   input wire logic uart2_aux_output_two,
   input wire logic [NUM_LD-1:0] func_irq_req,
   input wire logic [NUM_LD-1:0] func_dma_req,
   input wire logic [NUM_DMA-1:0] dma_ack_in,
   input wire logic sys_mgmt_enable,
   input wire logic sys_mgmt_req,
   output logic [NUM_IRQ-1:0] irq_line,
   output logic [NUM_IRQ-1:0] irq_line_oe,
   output logic sys_mgmt_irq_n,
   output logic [NUM_DMA-1:0] dma_request,
   output logic [NUM_DMA-1:0] dma_request_oe,
   output logic [NUM_LD-1:0] func_dma_ack
);
   // ----------------------------------------------------------------
   // Address decode helper
   // ----------------------------------------------------------------
   // Upper nibble is only qualified when full decode is switched on
   function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] base,
                                     input logic full16, input logic [11:0] mask);
      logic low_ok;
      low_ok = ((addr[11:0] & mask) == (base[11:0] & mask)); // R1
      addr_hit = full16 ? (low_ok && (addr[15:12] == 4'h0)) : low_ok; // R1
   endfunction

   // Map a device number onto a bank slot, MSB flags a hit
   function automatic logic [2:0] ld_slot(input logic [7:0] num);
      case (num)
         LD_FLOPPY: ld_slot = {1'b1, 2'(SLOT_FLOPPY)};
         LD_PARALLEL: ld_slot = {1'b1, 2'(SLOT_PARALLEL)};
         LD_SERIAL1: ld_slot = {1'b1, 2'(SLOT_SERIAL1)};
         LD_SERIAL2: ld_slot = {1'b1, 2'(SLOT_SERIAL2)};
         default: ld_slot = 3'h0;
      endcase
   endfunction

   logic [7:0] index_reg;
   logic [7:0] ld_num_reg;
   logic [7:0] osc_cfg_reg;
   logic [15:0] cfg_base_reg;
   logic cfg_base_moved_reg;
   logic [7:0] io_rdata_reg;
   logic io_rvalid_reg;
   logic [NUM_LD-1:0] dev_hit_reg;
   logic [NUM_IRQ-1:0] irq_line_reg;
   logic [NUM_IRQ-1:0] irq_line_oe_reg;
   logic sys_mgmt_irq_n_reg;
   logic [NUM_DMA-1:0] dma_request_reg;
   logic [NUM_DMA-1:0] dma_request_oe_reg;
   logic [NUM_LD-1:0] func_dma_ack_reg;

   logic [15:0] cfg_base;
   logic [15:0] cfg_data_addr;
   logic full16;
   logic idx_wr;
   logic data_wr;
   logic data_rd;
   logic idx_rd;
   logic [2:0] slot;
   logic [NUM_LD-1:0] bank_wr;
   logic [NUM_LD-1:0][7:0] bank_rdata;
   logic [NUM_LD-1:0] bank_act;
   logic [NUM_LD-1:0][15:0] bank_base;
   logic [NUM_LD-1:0][3:0] bank_irq;
   logic [NUM_LD-1:0][2:0] bank_dma;
   logic [NUM_LD-1:0] ld_live;
   logic [NUM_LD-1:0] irq_gate;
   logic [NUM_LD-1:0] dma_gate;
   logic [NUM_IRQ-1:0] irq_avail;
   logic [NUM_IRQ-1:0] rt_irq_level;
   logic [NUM_IRQ-1:0] rt_irq_used;
   logic [NUM_DMA-1:0] rt_dma_level;
   logic [NUM_DMA-1:0] rt_dma_used;
   logic [NUM_LD-1:0] rt_dack;
   logic floppy_on;
   logic ecp_forced;
   logic [7:0] global_rdata;

   // ----------------------------------------------------------------
   // Configuration port decode
   // ----------------------------------------------------------------
   // Strap value stands until software moves the port, so no latch at reset
   assign cfg_base = cfg_base_moved_reg ? cfg_base_reg :
                     (cfg_port_select_strap ? CFG_BASE_STRAP1 : CFG_BASE_STRAP0); // R2
   assign cfg_data_addr = cfg_base + 16'h0001;
   assign full16 = osc_cfg_reg[OSC_FULL_DECODE_BIT];
   assign idx_wr = io_wr && addr_hit(io_addr, cfg_base, full16, EXACT_MASK); // R20
   assign idx_rd = io_rd && addr_hit(io_addr, cfg_base, full16, EXACT_MASK);
   assign data_wr = io_wr && addr_hit(io_addr, cfg_data_addr, full16, EXACT_MASK); // R20
   assign data_rd = io_rd && addr_hit(io_addr, cfg_data_addr, full16, EXACT_MASK);
   assign slot = ld_slot(ld_num_reg);

   // Only device-level indices reach a bank
   always_comb begin
      bank_wr = '0;
      if (data_wr && slot[2] && (index_reg >= IDX_LD_FIRST)) begin
         bank_wr[slot[1:0]] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Global configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         index_reg <= 8'h00;
      end else if (ce && idx_wr) begin
         index_reg <= io_wdata; // R20
      end
   end

   // Port moves as soon as either half is written; the other half keeps its current value
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ld_num_reg <= 8'h00;
         osc_cfg_reg <= 8'h00;
         cfg_base_reg <= 16'h0000;
         cfg_base_moved_reg <= 1'b0;
      end else if (ce && data_wr) begin
         case (index_reg)
            IDX_LD_NUM: ld_num_reg <= io_wdata;
            IDX_OSC_CFG: osc_cfg_reg <= io_wdata; // R1
            IDX_CFG_BASE_LO: begin
               cfg_base_reg[7:0] <= io_wdata; // R2
               cfg_base_reg[15:8] <= cfg_base[15:8];
               cfg_base_moved_reg <= 1'b1;
            end
            IDX_CFG_BASE_HI: begin
               cfg_base_reg[15:8] <= io_wdata; // R2
               cfg_base_reg[7:0] <= cfg_base[7:0];
               cfg_base_moved_reg <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Per-device register banks
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_LD; g++) begin : g_bank
      ld_cfg_bank #(
         .IRQ_RST((g == SLOT_FLOPPY) ? IRQ_SEL_RST_FLOPPY : IRQ_SEL_RST_OTHER),
         .DMA_RST((g == SLOT_FLOPPY) ? DMA_SEL_RST_FLOPPY : DMA_SEL_RST_OTHER)
      ) u_bank (
         .ref_clk(ref_clk),
         .rst(rst),
         .soft_rst(soft_rst),
         .ce(ce),
         .wr_en(bank_wr[g]),
         .index(index_reg),
         .wdata(io_wdata),
         .rdata(bank_rdata[g]),
         .activate(bank_act[g]),
         .base(bank_base[g]),
         .irq_sel(bank_irq[g]),
         .dma_sel(bank_dma[g])
      );
   end

   // Live means activated with a usable base address
   always_comb begin
      for (int i = 0; i < NUM_LD; i++) begin
         ld_live[i] = bank_act[i] && (bank_base[i] != 16'h0000); // R17
      end
   end

   // ----------------------------------------------------------------
   // Function enables feeding the router
   // ----------------------------------------------------------------
   assign floppy_on = floppy_dma_gate && !floppy_powered_down; // R18
   assign ecp_forced = (ecp_mode_field == ECP_MODE_FIFO) || (ecp_mode_field == ECP_MODE_ECP) ||
                       (ecp_mode_field == ECP_MODE_TEST); // R19
   always_comb begin
      irq_gate = '0;
      dma_gate = '0;
      irq_gate[SLOT_FLOPPY] = floppy_on; // R7
      dma_gate[SLOT_FLOPPY] = floppy_on; // R18
      // In ECP the service mask still has the last word on the interrupt
      irq_gate[SLOT_PARALLEL] = parallel_ecp_mode ?
                                ((ecp_forced || port_irq_gate) && !ecp_service_irq_mask) :
                                port_irq_gate; // R8
      dma_gate[SLOT_PARALLEL] = parallel_ecp_mode && ecp_dma_gate; // R19
      irq_gate[SLOT_SERIAL1] = (|uart1_irq_enable_reg) && uart1_aux_output_two; // R9
      irq_gate[SLOT_SERIAL2] = (|uart2_irq_enable_reg) && uart2_aux_output_two; // R9
   end
   assign irq_avail = serial_irq_mode ? {NUM_IRQ{1'b1}} : DIRECT_IRQ_AVAIL; // R12

   irq_dma_router #(
      .NLD(NUM_LD),
      .NIRQ(NUM_IRQ),
      .NDMA(NUM_DMA)
   ) u_router (
      .irq_sel(bank_irq),
      .dma_sel(bank_dma),
      .ld_live(ld_live),
      .irq_gate(irq_gate),
      .dma_gate(dma_gate),
      .irq_req(func_irq_req),
      .dma_req(func_dma_req),
      .dack(dma_ack_in),
      .irq_avail(irq_avail),
      .irq_level(rt_irq_level),
      .irq_used(rt_irq_used),
      .dma_level(rt_dma_level),
      .dma_used(rt_dma_used),
      .dack_out(rt_dack)
   );

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   // Active-high lines; ECP/EPP sources arrive already shaped as levels
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_line_reg <= '0;
         irq_line_oe_reg <= '0;
         dma_request_reg <= '0;
         dma_request_oe_reg <= '0;
         func_dma_ack_reg <= '0;
      end else if (ce) begin
         irq_line_reg <= rt_irq_level & rt_irq_used; // R4
         irq_line_oe_reg <= rt_irq_used; // R10
         dma_request_reg <= rt_dma_level & rt_dma_used; // R15
         dma_request_oe_reg <= rt_dma_used; // R16
         func_dma_ack_reg <= rt_dack; // R16
      end
   end

   // Line 2 sharing is left to software ordering
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sys_mgmt_irq_n_reg <= 1'b1;
      end else if (ce) begin
         sys_mgmt_irq_n_reg <= !(sys_mgmt_enable && sys_mgmt_req); // R5
      end
   end

   // Read path: one cycle after the strobe, unmapped reads zero
   always_comb begin
      case (index_reg)
         IDX_LD_NUM: global_rdata = ld_num_reg;
         IDX_OSC_CFG: global_rdata = osc_cfg_reg;
         IDX_CFG_BASE_LO: global_rdata = cfg_base[7:0];
         IDX_CFG_BASE_HI: global_rdata = cfg_base[15:8];
         default: global_rdata = (slot[2] && (index_reg >= IDX_LD_FIRST)) ?
                                 bank_rdata[slot[1:0]] : 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         io_rdata_reg <= 8'h00;
         io_rvalid_reg <= 1'b0;
      end else if (ce) begin
         io_rvalid_reg <= idx_rd || data_rd;
         if (idx_rd) io_rdata_reg <= index_reg;
         else if (data_rd) io_rdata_reg <= global_rdata; // R20
      end
   end

   // Cycle hits on each live device's 8-byte window
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dev_hit_reg <= '0;
      end else if (ce) begin
         for (int i = 0; i < NUM_LD; i++) begin
            dev_hit_reg[i] <= (io_rd || io_wr) && ld_live[i] &&
                              addr_hit(io_addr, bank_base[i], full16, DEV_SPAN_MASK); // R1
         end
      end
   end

   assign io_rdata = io_rdata_reg;
   assign io_rvalid = io_rvalid_reg;
   assign dev_hit = dev_hit_reg;
   assign irq_line = irq_line_reg;
   assign irq_line_oe = irq_line_oe_reg;
   assign sys_mgmt_irq_n = sys_mgmt_irq_n_reg;
   assign dma_request = dma_request_reg;
   assign dma_request_oe = dma_request_oe_reg;
   assign func_dma_ack = func_dma_ack_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_index_write;
      ce && idx_wr |=> index_reg == $past(io_wdata);
   endproperty
   a_index_write: assert property (p_index_write) else $error("index not taken"); // R20

   property p_strap_base;
      $past(rst) |-> cfg_base == (cfg_port_select_strap ? CFG_BASE_STRAP1 : CFG_BASE_STRAP0);
   endproperty
   a_strap_base: assert property (p_strap_base) else $error("config port not at strap"); // R2

   property p_irq_reset;
      $past(rst) |-> bank_irq[SLOT_FLOPPY] == IRQ_SEL_RST_FLOPPY[3:0] &&
                     bank_irq[SLOT_PARALLEL] == IRQ_SEL_RST_OTHER[3:0];
   endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("irq select reset wrong"); // R6

   property p_dma_reset;
      $past(rst) |-> bank_dma[SLOT_FLOPPY] == DMA_SEL_RST_FLOPPY[2:0] &&
                     bank_dma[SLOT_SERIAL2] == DMA_SEL_RST_OTHER[2:0];
   endproperty
   a_dma_reset: assert property (p_dma_reset) else $error("dma select reset wrong"); // R14

   property p_smi_low;
      ce && sys_mgmt_enable && sys_mgmt_req |=> !sys_mgmt_irq_n;
   endproperty
   a_smi_low: assert property (p_smi_low) else $error("smi not driven low"); // R5

   property p_unused_oe;
      ce && !rt_irq_used[3] |=> !irq_line_oe[3] && !irq_line[3];
   endproperty
   a_unused_oe: assert property (p_unused_oe) else $error("unselected line driven"); // R10

   property p_floppy_off;
      ce && !floppy_on |=> !func_dma_ack[SLOT_FLOPPY];
   endproperty
   a_floppy_off: assert property (p_floppy_off) else $error("floppy dma while gated"); // R18

   property p_dma_none;
      ce && !dma_sel_valid(bank_dma[SLOT_PARALLEL]) |=> !func_dma_ack[SLOT_PARALLEL];
   endproperty
   a_dma_none: assert property (p_dma_none) else $error("ack with no channel"); // R13

   property p_ecp_forced;
      ce && parallel_ecp_mode && ecp_forced && !ecp_service_irq_mask && ld_live[SLOT_PARALLEL]
         && func_irq_req[SLOT_PARALLEL] && irq_sel_valid(bank_irq[SLOT_PARALLEL])
         && irq_avail[bank_irq[SLOT_PARALLEL]] |=> irq_line[$past(bank_irq[SLOT_PARALLEL])];
   endproperty
   a_ecp_forced: assert property (p_ecp_forced) else $error("ecp irq not forced on"); // R19

   property p_read_answer;
      ce && data_rd |=> io_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("no read answer"); // R20

   c_relocate: cover property (ce && data_wr && index_reg == IDX_CFG_BASE_LO);
   c_irq_out: cover property (irq_line[SLOT_PARALLEL + 3]);
   c_dma_out: cover property (dma_request[1]);
endmodule

// ==== host_model.sv ====
`timescale 1ns/1ps
// ---------------------------------
// Host chipset, index/data cycles
// ---------------------------------
module host_model (
   input wire logic ref_clk,
   input wire logic io_rvalid,
   input wire logic [7:0] io_rdata,
   output logic io_wr,
   output logic io_rd,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata
);
   initial {io_wr, io_rd, io_addr, io_wdata} = '0;
   // One strobe cycle; data inverted after so a stale byte never looks valid
   task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      {io_rd, io_wr, io_addr, io_wdata} = {rd, !rd, a, d};
      @(negedge ref_clk);
      {io_rd, io_wr, io_wdata} = {2'h0, ~d};
   endtask
   // Index to the port, value to the port plus one
   task automatic put(input logic [7:0] idx, input logic [7:0] val);
      acc(1'h0, 16'h002E, idx);
      acc(1'h0, 16'h002F, val);
   endtask
   // Answer pulse lands within two edges of the read strobe
   task automatic get(input logic [7:0] idx, output logic [7:0] val);
      acc(1'h0, 16'h002E, idx);
      acc(1'h1, 16'h002F, 8'h00);
      for (int i = 0; i < 2; i++) begin
         if (io_rvalid === 1'h1) val = io_rdata;
         @(negedge ref_clk);
      end
   endtask
endmodule

// ==== tb_logical_device_irq_dma_routing.sv ====
`timescale 1ns/1ps
module tb_logical_device_irq_dma_routing;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic soft_rst = 1'h0;
   logic floppy_dma_gate = 1'h1;
   logic ce = 1'h1, serial_irq_mode = 1'h0, floppy_powered_down = 1'h0, port_irq_gate = 1'h0;
   logic parallel_ecp_mode = 1'h0, ecp_service_irq_mask = 1'h0, ecp_dma_gate = 1'h0;
   logic uart1_aux_output_two = 1'h0;
   logic [2:0] ecp_mode_field = 3'h0, dma_ack_in = 3'h0;
   logic [3:0] uart1_irq_enable_reg = 4'h0, func_irq_req = 4'hF, func_dma_req = 4'hF;
   logic [3:0] dev_hit, func_dma_ack;
   logic sys_mgmt_enable = 1'h0;
   logic sys_mgmt_req = 1'h0;
   logic io_wr, io_rd, io_rvalid, sys_mgmt_irq_n;
   logic [15:0] io_addr, irq_line, irq_line_oe;
   logic [7:0] io_wdata, io_rdata, rv;
   logic [2:0] dma_request, dma_request_oe;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   // Irq select, dma select, gate, expected lines, expected channels
   // Line 2 is handed out only while the system-management function is off
   logic [26:0] rows [6] = '{{4'h0, 3'h0, 1'h1, 16'h0, 3'h0}, {4'h2, 3'h1, 1'h1, 16'h4, 3'h1},
      {4'h6, 3'h2, 1'h1, 16'h40, 3'h2}, {4'hF, 3'h3, 1'h1, 16'h8000, 3'h4},
      {4'h6, 3'h4, 1'h1, 16'h40, 3'h0}, {4'h9, 3'h3, 1'h0, 16'h0, 3'h0}};
   ld_irq_dma_top ld_irq_dma_top_i (.ref_clk, .rst, .soft_rst, .ce,
      .cfg_port_select_strap(1'h0), .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
      .io_rvalid, .dev_hit, .serial_irq_mode, .floppy_dma_gate,
      .floppy_powered_down, .port_irq_gate, .parallel_ecp_mode,
      .parallel_epp_mode(1'h0), .ecp_mode_field, .ecp_service_irq_mask,
      .ecp_dma_gate, .uart1_irq_enable_reg, .uart1_aux_output_two,
      .uart2_irq_enable_reg(4'h0), .uart2_aux_output_two(1'h0), .func_irq_req,
      .func_dma_req, .dma_ack_in, .sys_mgmt_enable, .sys_mgmt_req, .irq_line,
      .irq_line_oe, .sys_mgmt_irq_n, .dma_request, .dma_request_oe, .func_dma_ack);
   host_model host_model_i (.ref_clk, .io_rvalid, .io_rdata, .io_wr, .io_rd, .io_addr,
      .io_wdata);
   initial forever #2 ref_clk = ~ref_clk;
   // ---------------------------------
   // Compare and verdict
   // ---------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, far above the roughly 160 cycles needed
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      repeat (20) @(negedge ref_clk);
      rst = 1'h0;
      host_model_i.put(8'h07, 8'h03);
      host_model_i.get(8'h74, rv);
      chk("dma_rst", {8'h0, rv}, 16'h4);
      host_model_i.put(8'h07, 8'h00);
      host_model_i.get(8'h70, rv);
      chk("irq_rst", {8'h0, rv}, 16'h6);
      host_model_i.get(8'h74, rv);
      chk("dma_rst", {8'h0, rv}, 16'h2);
      // Make the floppy slot live at 0x3F0
      host_model_i.put(8'h60, 8'h03);
      host_model_i.put(8'h61, 8'hF0);
      host_model_i.put(8'h30, 8'h01);
      for (int i = 0; i < 6; i++) begin
         host_model_i.put(8'h70, {4'h0, rows[i][26:23]});
         host_model_i.put(8'h74, {5'h0, rows[i][22:20]});
         floppy_dma_gate = rows[i][19];
         repeat (3) @(negedge ref_clk);
         chk("irq", irq_line, rows[i][18:3]);
         chk("irq_oe", irq_line_oe, rows[i][18:3]);
         chk("dma", {13'h0, dma_request}, {13'h0, rows[i][2:0]});
         chk("dma_oe", {13'h0, dma_request_oe}, {13'h0, rows[i][2:0]});
      end
      // Soft reset brings the select back to its default
      soft_rst = 1'h1;
      @(negedge ref_clk);
      soft_rst = 1'h0;
      host_model_i.get(8'h70, rv);
      chk("irq_soft", {8'h0, rv}, 16'h6);
      // A read inside the floppy window flags that slot
      host_model_i.acc(1'h1, 16'h03F2, 8'h00);
      chk("hit", {12'h0, dev_hit}, 16'h1);
      floppy_dma_gate = 1'h1;
      dma_ack_in = 3'h2;
      sys_mgmt_enable = 1'h1;
      sys_mgmt_req = 1'h1;
      repeat (2) @(negedge ref_clk);
      chk("smi", {15'h0, sys_mgmt_irq_n}, 16'h0);
      chk("dma_soft", {13'h0, dma_request}, 16'h2);
      chk("ack", {12'h0, func_dma_ack}, 16'h1);
      sys_mgmt_req = 1'h0;
      repeat (2) @(negedge ref_clk);
      chk("smi", {15'h0, sys_mgmt_irq_n}, 16'h1);
      // Parallel port in FIFO mode: line forced on until the service mask is set
      host_model_i.put(8'h07, 8'h03);
      host_model_i.put(8'h60, 8'h03);
      host_model_i.put(8'h61, 8'h78);
      host_model_i.put(8'h30, 8'h01);
      host_model_i.put(8'h70, 8'h07);
      {parallel_ecp_mode, ecp_mode_field} = 4'hA;
      repeat (2) @(negedge ref_clk);
      chk("ecp_irq", irq_line, 16'hC0);
      ecp_service_irq_mask = 1'h1;
      repeat (2) @(negedge ref_clk);
      chk("ecp_mask", irq_line_oe, 16'h40);
      summarize();
   end
endmodule
